// ---- hdl/gpaf_pkg.sv ----
// Summary of operation
// - Mode field per pin: 00 input, 01 output, 10 alternate, 11 analog.
// - Drive type bit: 0 push-pull, 1 open-drain, for output and alternate modes.
// - Bias field: 00 none, 01 up, 10 down, 11 acts as none.
// - Slew field applies in output and alternate modes, ignored otherwise.
// - After reset alternates are inactive except on the debug pins, and most pins float as inputs.
// - Port A pins 12-14 pull up and pin 11 pulls down after reset.
// - Output mode drives the pin from the drive value register bit.
// - Open-drain drives only low; a high output releases the pin.
// - Pin levels are sampled into the sample register every clock.
// - Each pin selects one of sixteen alternate functions, at most one connected.
// - Pins 0-7 select from the low register, pins 8-15 from the high.
// - Reset sets every alternate selection to function zero.
// - The selected function reaches the pin only in alternate mode.
// - Debug pins come out of every reset in alternate mode.
// - An enabled special function overrides the pin's mode, drive type and bias; slew and hysteresis still follow the port configuration.
// - Word, half-word and byte accesses are accepted.
// - Drive value register is read/write; sample register is read-only.
// - Sixteen pins, each with mode, type, slew and bias fields.
// - Set/clear write sets or clears drive bits; zeros ignored; set wins.
// - A correct word lock sequence freezes selected pins' configuration until reset.
// - Mask bits block configuration writes; the mask itself is freely accessible.
`default_nettype none
package gpaf_pkg;
	localparam int gpaf_pins = 16;
	// Register byte offsets
	localparam logic [7:0] gpaf_a_mode = 8'h00;
	localparam logic [7:0] gpaf_a_dtype = 8'h04;
	localparam logic [7:0] gpaf_a_slew = 8'h08;
	localparam logic [7:0] gpaf_a_bias = 8'h0c;
	localparam logic [7:0] gpaf_a_sample = 8'h10;
	localparam logic [7:0] gpaf_a_drive = 8'h14;
	localparam logic [7:0] gpaf_a_setclr = 8'h18;
	localparam logic [7:0] gpaf_a_freeze = 8'h1c;
	localparam logic [7:0] gpaf_a_fsel_lo = 8'h20;
	localparam logic [7:0] gpaf_a_fsel_hi = 8'h24;
	localparam logic [7:0] gpaf_a_clronly = 8'h28;
	localparam logic [7:0] gpaf_a_wmask = 8'h2c;
	localparam logic [7:0] gpaf_a_hyst = 8'h30;
	// Mode field codes
	localparam logic [1:0] gpaf_m_in = 2'h0;
	localparam logic [1:0] gpaf_m_out = 2'h1;
	localparam logic [1:0] gpaf_m_alt = 2'h2;
	localparam logic [1:0] gpaf_m_ana = 2'h3;
	// Bias field codes
	localparam logic [1:0] gpaf_b_up = 2'h1;
	localparam logic [1:0] gpaf_b_dn = 2'h2;
	// Reset values; port A has debug pins in alternate mode and biased pins
	localparam logic [31:0] gpaf_rst_mode_a = 32'h2800_0000;
	localparam logic [31:0] gpaf_rst_bias_a = 32'h1580_0000;
	localparam logic [31:0] gpaf_rst_zero = 32'h0000_0000;
	// Freeze register fields
	localparam int gpaf_key_bit = 16;
	localparam logic [3:0] gpaf_be_word = 4'hf;
	// Freeze key sequence states
	typedef enum logic [1:0] {
		gpaf_lk_idle = 2'b00,
		gpaf_lk_one = 2'b01,
		gpaf_lk_zero = 2'b10,
		gpaf_lk_done = 2'b11
	} gpaf_lock_t;
endpackage
`default_nettype wire

// ---- hdl/gpaf_port.sv ----
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`default_nettype none
module gpaf_port import gpaf_pkg::*; #(
	parameter bit PORT_IS_A = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe_n,
	output logic [15:0] pull_up_en,
	output logic [15:0] pull_dn_en,
	output logic [15:0] analog_en,
	output logic [15:0] hyst_en,
	output logic [31:0] slew_rate_field,
	input wire logic [255:0] alt_out,
	input wire logic [255:0] alt_oe,
	output logic [255:0] alt_in,
	input wire logic [15:0] special_en,
	input wire logic [15:0] special_out,
	input wire logic [15:0] special_oe
);
	// ======================================================
	// Reset images
	localparam logic [31:0] rst_mode = PORT_IS_A ? gpaf_rst_mode_a : gpaf_rst_zero;
	localparam logic [31:0] rst_bias = PORT_IS_A ? gpaf_rst_bias_a : gpaf_rst_zero;

	logic [31:0] pin_mode_cfg_q;
	logic [15:0] drive_type_cfg_q;
	logic [31:0] slew_rate_cfg_q;
	logic [31:0] weak_bias_cfg_q;
	logic [15:0] hysteresis_cfg_q;
	logic [15:0] pin_drive_value_q;
	logic [31:0] func_select_low_q;
	logic [31:0] func_select_high_q;
	logic [15:0] config_write_mask_q;
	logic [15:0] freeze_sel_q;
	gpaf_lock_t lock_q;
	logic [15:0] sync1_q;
	logic [15:0] pin_sample_value_q;
	logic wait_q;
	logic [31:0] rdata_q;

	logic [31:0] bmask;
	logic [15:0] prot1;
	logic [31:0] prot2;
	logic [31:0] prot4_lo;
	logic [31:0] prot4_hi;
	logic req;
	logic wr_go;
	logic [15:0] bm16;
	logic [63:0] fsel;

	// ======================================================
	// Bus slave: one wait cycle, then a single-cycle answer
	assign req = avs_read | avs_write;
	assign wr_go = avs_write & ~wait_q;
	assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign bm16 = bmask[15:0];
	assign fsel = {func_select_high_q, func_select_low_q};

	// Wait request drops for one cycle per access
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(req & wait_q);
		end
	end

	// Read data captured while waiting
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read & wait_q) begin
			unique case (avs_address)
				gpaf_a_mode: rdata_q <= pin_mode_cfg_q;
				gpaf_a_dtype: rdata_q <= {16'h0000, drive_type_cfg_q};
				gpaf_a_slew: rdata_q <= slew_rate_cfg_q;
				gpaf_a_bias: rdata_q <= weak_bias_cfg_q;
				gpaf_a_sample: rdata_q <= {16'h0000, pin_sample_value_q};
				gpaf_a_drive: rdata_q <= {16'h0000, pin_drive_value_q};
				gpaf_a_freeze: rdata_q <= {15'h0000, lock_q == gpaf_lk_done, freeze_sel_q};
				gpaf_a_fsel_lo: rdata_q <= func_select_low_q;
				gpaf_a_fsel_hi: rdata_q <= func_select_high_q;
				gpaf_a_wmask: rdata_q <= {16'h0000, config_write_mask_q};
				gpaf_a_hyst: rdata_q <= {16'h0000, hysteresis_cfg_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ======================================================
	// Per-pin write protection from freeze and mask
	genvar gi;
	generate
		for (gi = 0; gi < gpaf_pins; gi++) begin : g_prot
			assign prot1[gi] = (lock_q == gpaf_lk_done & freeze_sel_q[gi])
				| config_write_mask_q[gi];
			assign prot2[2*gi+1:2*gi] = {2{prot1[gi]}};
			if (gi < 8) begin : g_lo
				assign prot4_lo[4*gi+3:4*gi] = {4{prot1[gi]}};
			end else begin : g_hi
				assign prot4_hi[4*(gi-8)+3:4*(gi-8)] = {4{prot1[gi]}};
			end
		end
	endgenerate

	// Mode fields; debug pins leave reset in alternate mode
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_mode_cfg_q <= rst_mode;
		end else if (wr_go && avs_address == gpaf_a_mode) begin
			pin_mode_cfg_q <= (pin_mode_cfg_q & ~(bmask & ~prot2))
				| (avs_writedata & bmask & ~prot2);
		end
	end

	// Bias fields; biased port A pins come out of reset pulled
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			weak_bias_cfg_q <= rst_bias;
		end else if (wr_go && avs_address == gpaf_a_bias) begin
			weak_bias_cfg_q <= (weak_bias_cfg_q & ~(bmask & ~prot2))
				| (avs_writedata & bmask & ~prot2);
		end
	end

	// Slew fields, byte lanes honoured
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			slew_rate_cfg_q <= 32'h0000_0000;
		end else if (wr_go && avs_address == gpaf_a_slew) begin
			slew_rate_cfg_q <= (slew_rate_cfg_q & ~(bmask & ~prot2))
				| (avs_writedata & bmask & ~prot2);
		end
	end

	// Drive type bits, low half only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_type_cfg_q <= 16'h0000;
		end else if (wr_go && avs_address == gpaf_a_dtype) begin
			drive_type_cfg_q <= (drive_type_cfg_q & ~(bm16 & ~prot1))
				| (avs_writedata[15:0] & bm16 & ~prot1);
		end
	end

	// Hysteresis bits, low half only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hysteresis_cfg_q <= 16'h0000;
		end else if (wr_go && avs_address == gpaf_a_hyst) begin
			hysteresis_cfg_q <= (hysteresis_cfg_q & ~(bm16 & ~prot1))
				| (avs_writedata[15:0] & bm16 & ~prot1);
		end
	end

	// Alternate function selection for pins 0 to 7
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			func_select_low_q <= 32'h0000_0000;
		end else if (wr_go && avs_address == gpaf_a_fsel_lo) begin
			func_select_low_q <= (func_select_low_q & ~(bmask & ~prot4_lo))
				| (avs_writedata & bmask & ~prot4_lo);
		end
	end

	// Alternate function selection for pins 8 to 15
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			func_select_high_q <= 32'h0000_0000;
		end else if (wr_go && avs_address == gpaf_a_fsel_hi) begin
			func_select_high_q <= (func_select_high_q & ~(bmask & ~prot4_hi))
				| (avs_writedata & bmask & ~prot4_hi);
		end
	end

	// Mask register, never protected itself
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			config_write_mask_q <= 16'h0000;
		end else if (wr_go && avs_address == gpaf_a_wmask) begin
			config_write_mask_q <= (config_write_mask_q & ~bm16)
				| (avs_writedata[15:0] & bm16);
		end
	end

	// ======================================================
	// Drive value: direct write, set/clear and clear-only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_drive_value_q <= 16'h0000;
		end else if (wr_go) begin
			unique case (avs_address)
				gpaf_a_drive: begin
					pin_drive_value_q <= (pin_drive_value_q & ~bm16)
						| (avs_writedata[15:0] & bm16);
				end
				gpaf_a_setclr: begin
					pin_drive_value_q <= (pin_drive_value_q
						& ~(avs_writedata[31:16] & bmask[31:16]))
						| (avs_writedata[15:0] & bm16);
				end
				gpaf_a_clronly: begin
					pin_drive_value_q <= pin_drive_value_q & ~(avs_writedata[15:0] & bm16);
				end
				default: pin_drive_value_q <= pin_drive_value_q;
			endcase
		end
	end

	// ======================================================
	// Freeze selection follows each word write until the key completes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			freeze_sel_q <= 16'h0000;
		end else if (wr_go && avs_address == gpaf_a_freeze && lock_q != gpaf_lk_done
			&& avs_byteenable == gpaf_be_word) begin
			freeze_sel_q <= avs_writedata[15:0];
		end
	end

	// Freeze key sequence: word writes key 1, 0, 1 with equal selection
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_q <= gpaf_lk_idle;
		end else if (wr_go && avs_address == gpaf_a_freeze && lock_q != gpaf_lk_done) begin
			if (avs_byteenable != gpaf_be_word) begin
				lock_q <= gpaf_lk_idle;
			end else begin
				unique case (lock_q)
					gpaf_lk_idle: begin
						lock_q <= avs_writedata[gpaf_key_bit] ? gpaf_lk_one : gpaf_lk_idle;
					end
					gpaf_lk_one: begin
						if (!avs_writedata[gpaf_key_bit] && avs_writedata[15:0] == freeze_sel_q) begin
							lock_q <= gpaf_lk_zero;
						end else begin
							lock_q <= avs_writedata[gpaf_key_bit] ? gpaf_lk_one : gpaf_lk_idle;
						end
					end
					gpaf_lk_zero: begin
						if (avs_writedata[gpaf_key_bit] && avs_writedata[15:0] == freeze_sel_q) begin
							lock_q <= gpaf_lk_done;
						end else begin
							lock_q <= gpaf_lk_idle;
						end
					end
					gpaf_lk_done: lock_q <= gpaf_lk_done;
				endcase
			end
		end
	end

	// ======================================================
	// Pin sampling, first stage of two
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 16'h0000;
		end else begin
			sync1_q <= pin_in;
		end
	end

	// Second stage is the only reader of the first
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_sample_value_q <= 16'h0000;
		end else begin
			pin_sample_value_q <= sync1_q;
		end
	end

	// ======================================================
	// Pad control per pin, registered outputs
	generate
		for (gi = 0; gi < gpaf_pins; gi++) begin : g_pad
			logic [1:0] mode;
			logic [1:0] bias;
			logic [3:0] sel;
			logic val;
			logic want;
			assign mode = pin_mode_cfg_q[2*gi+1:2*gi];
			assign bias = weak_bias_cfg_q[2*gi+1:2*gi];
			assign sel = fsel[4*gi+3:4*gi];
			// Output value and drive request by mode
			always_comb begin
				val = 1'b0;
				want = 1'b0;
				if (special_en[gi]) begin
					val = special_out[gi];
					want = special_oe[gi];
				end else if (mode == gpaf_m_out) begin
					val = pin_drive_value_q[gi];
					want = 1'b1;
				end else if (mode == gpaf_m_alt) begin
					val = alt_out[16*gi+sel];
					want = alt_oe[16*gi+sel];
				end
			end
			// Driver value and enable; open-drain releases a high
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					pin_out[gi] <= 1'b0;
					pin_oe_n[gi] <= 1'b1;
				end else begin
					pin_out[gi] <= val & ~(drive_type_cfg_q[gi] & ~special_en[gi]);
					pin_oe_n[gi] <= ~(want & ~(drive_type_cfg_q[gi] & ~special_en[gi] & val));
				end
			end
			// Pull-up request, off in analog mode
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					pull_up_en[gi] <= 1'b0;
				end else begin
					pull_up_en[gi] <= ~special_en[gi] & mode != gpaf_m_ana
						& bias == gpaf_b_up;
				end
			end
			// Pull-down request, off in analog mode
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					pull_dn_en[gi] <= 1'b0;
				end else begin
					pull_dn_en[gi] <= ~special_en[gi] & mode != gpaf_m_ana
						& bias == gpaf_b_dn;
				end
			end
			// Analog switch
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					analog_en[gi] <= 1'b0;
				end else begin
					analog_en[gi] <= ~special_en[gi] & mode == gpaf_m_ana;
				end
			end
			// Input hysteresis
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					hyst_en[gi] <= 1'b0;
				end else begin
					hyst_en[gi] <= hysteresis_cfg_q[gi];
				end
			end
			// Slew only in output and alternate modes
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					slew_rate_field[2*gi+1:2*gi] <= 2'h0;
				end else begin
					slew_rate_field[2*gi+1:2*gi] <= (mode == gpaf_m_out || mode == gpaf_m_alt)
						? slew_rate_cfg_q[2*gi+1:2*gi] : 2'h0;
				end
			end
			// Alternate inputs: only the selected function sees the pin
			for (genvar gf = 0; gf < 16; gf++) begin : g_af
				always_ff @(posedge ref_clk or negedge rst_b) begin
					if (!rst_b) begin
						alt_in[16*gi+gf] <= 1'b0;
					end else begin
						alt_in[16*gi+gf] <= mode == gpaf_m_alt && sel == gf
							&& pin_sample_value_q[gi];
					end
				end
			end
		end
	endgenerate

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
endmodule
`default_nettype wire

// ---- verification/gpaf_port_properties.sv ----
`default_nettype none
// ==============================================
// Port checker: bus handshake, pad outputs, mux
module gpaf_port_chk (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] pull_up_en,
	input wire logic [15:0] pull_dn_en,
	input wire logic [15:0] analog_en,
	input wire logic [31:0] slew_rate_field,
	input wire logic [255:0] alt_in,
	input wire logic [15:0] special_en,
	input wire logic [15:0] special_out,
	input wire logic [15:0] special_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic bad_mux;
	logic bad_slew;
	// Flags a pin with two live functions or slew left on in analog mode
	always_comb begin
		bad_mux = 1'b0;
		bad_slew = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (!$onehot0(alt_in[16*i+:16])) bad_mux = 1'b1;
			if (analog_en[i] && slew_rate_field[2*i+:2] != 2'h0) bad_slew = 1'b1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest) else $error("request not answered");
	a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	a_pull_excl: assert property ((pull_up_en & pull_dn_en) == 16'h0)
		else $error("both pulls on");
	a_analog_quiet: assert property (!$past(rst_b) || (analog_en & ~special_en &
		(~pin_oe_n | pull_up_en | pull_dn_en)) == 16'h0) else $error("analog pin not quiet");
	a_analog_slew: assert property (!bad_slew) else $error("slew on analog pin");
	a_mux_single: assert property (!bad_mux) else $error("two functions on a pin");
	a_special_wins: assert property (special_en != 16'h0 |=>
		(((pin_out ^ $past(special_out)) | (pin_oe_n ^ ~$past(special_oe)))
		& $past(special_en)) == 16'h0) else $error("override ignored");
	a_reset_float: assert property ($rose(rst_b) |-> &pin_oe_n && alt_in == 256'h0)
		else $error("pins active at reset");
endmodule
bind gpaf_port gpaf_port_chk u_chk (.ref_clk, .rst_b, .avs_read, .avs_write,
	.avs_waitrequest, .pin_out, .pin_oe_n, .pull_up_en, .pull_dn_en, .analog_en,
	.slew_rate_field, .alt_in, .special_en, .special_out, .special_oe);
`default_nettype wire

// ---- verification/gpaf_pad_model.sv ----
`default_nettype none
// ==============================================
// Far side: pad wires with weak bias, peripherals
module gpaf_pad_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] pull_up_en,
	input wire logic [15:0] pull_dn_en,
	output logic [15:0] pin_in,
	output logic [255:0] alt_out,
	output logic [255:0] alt_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip_q;
	// Toggle stands in for an undriven pad, so no stale level survives
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flip_q <= 1'b0;
		end else begin
			flip_q <= ~flip_q;
		end
	end
	// Wire level: port driver, else weak bias, else floating
	assign pin_in = (~pin_oe_n & pin_out) |
		(pin_oe_n & (pull_up_en | (~pull_dn_en & {16{flip_q}})));
	// Every function wants the pad; the pattern tells functions apart
	assign alt_out = {16{16'h8421}};
	assign alt_oe = {256{1'b1}};
endmodule
`default_nettype wire

// ---- verification/gpaf_port_tb_top.sv ----
`default_nettype none
// ==============================================
// Bench top: bus tasks, register rows, pin cases
module gpaf_port_tb_top import gpaf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] wa;
		logic [31:0] wd;
		logic [7:0] ra;
		logic [31:0] ex;
	} gpaf_row_t;
	logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [7:0] avs_address = 8'h00;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, slew_rate_field, q;
	logic [15:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_dn_en, analog_en, hyst_en, e_out;
	logic [15:0] special_en = 16'h0, special_out = 16'h0, special_oe = 16'h0;
	logic [255:0] alt_out, alt_oe, alt_in, e_in;
	int n_fail, comparisons, cyc;
	gpaf_row_t rows [6] = '{
		'{gpaf_a_drive, 32'h0000_a5a5, gpaf_a_drive, 32'h0000_a5a5},
		'{gpaf_a_setclr, 32'h0101_0f00, gpaf_a_drive, 32'h0000_afa4},
		'{gpaf_a_clronly, 32'h0000_00f0, gpaf_a_drive, 32'h0000_af04},
		'{8'h40, 32'h1234_5678, 8'h40, 32'h0},
		'{gpaf_a_fsel_lo, 32'h7654_3210, gpaf_a_fsel_lo, 32'h7654_3210},
		'{gpaf_a_fsel_hi, 32'hfedc_ba98, gpaf_a_slew, 32'h0}};
	gpaf_port #(.PORT_IS_A(1'b1)) u_gpaf_port (.ref_clk, .rst_b, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.pin_in, .pin_out, .pin_oe_n, .pull_up_en, .pull_dn_en, .analog_en, .hyst_en,
		.slew_rate_field, .alt_out, .alt_oe, .alt_in, .special_en, .special_out, .special_oe);
	gpaf_pad_model u_gpaf_pad_model (.ref_clk, .rst_b, .pin_out, .pin_oe_n, .pull_up_en,
		.pull_dn_en, .pin_in, .alt_out, .alt_oe);
	// Clock and hang guard
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic check(input logic [255:0] s, input logic [255:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t seen %0h want %0h", $time, s, e);
		end
	endtask
	// One bus access held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40) n_fail++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		check(q, e);
	endtask
	task automatic settle();
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra, rows[i].ex);
		end
		wr(gpaf_a_slew, 32'hffff_ffff);
		wr(gpaf_a_mode, 32'h5555_5555);
		settle();
		check({pin_out, pin_oe_n}, 32'haf04_0000);
		check(slew_rate_field, 32'hffff_ffff);
		rd(gpaf_a_sample, 32'h0000_af04);
		wr(gpaf_a_dtype, 32'h0000_ffff);
		settle();
		check(pin_oe_n, 16'haf04);
		wr(gpaf_a_dtype, 32'h0);
		wr(gpaf_a_mode, 32'haaaa_aaaa);
		settle();
		e_in = '0;
		for (int i = 0; i < 16; i++) begin
			e_out[i] = alt_out[17*i];
			e_in[17*i] = alt_out[17*i];
		end
		check(pin_out, e_out);
		check(alt_in, e_in);
		wr(gpaf_a_mode, 32'hffff_ffff);
		settle();
		check({analog_en, pin_oe_n, slew_rate_field, pull_up_en, pull_dn_en},
			96'hffff_ffff_0000_0000_0000_0000);
		wr(gpaf_a_mode, 32'h0);
		wr(gpaf_a_bias, 32'h0000_0036);
		settle();
		check({pull_up_en, pull_dn_en, pin_oe_n}, 48'h0002_0001_ffff);
		wr(gpaf_a_wmask, 32'h1);
		wr(gpaf_a_mode, 32'h5555_5555);
		rd(gpaf_a_mode, 32'h5555_5554);
		rd(gpaf_a_wmask, 32'h1);
		wr(gpaf_a_wmask, 32'h0);
		wr(gpaf_a_freeze, 32'h0001_0002);
		wr(gpaf_a_freeze, 32'h0000_0002);
		wr(gpaf_a_freeze, 32'h0001_0002);
		bus(1'b0, gpaf_a_freeze, 32'h0, 4'hf);
		check(q[16], 1'b1);
		wr(gpaf_a_mode, 32'h0);
		rd(gpaf_a_mode, 32'h0000_0004);
		wr(gpaf_a_hyst, 32'h0000_ffff);
		settle();
		check(hyst_en, 16'hfffd);
		bus(1'b1, gpaf_a_drive, 32'hffff_ffff, 4'h2);
		rd(gpaf_a_drive, 32'h0000_ff04);
		@(posedge ref_clk);
		special_en <= 16'h1;
		special_out <= 16'h1;
		special_oe <= 16'h1;
		settle();
		check({pin_out[0], pin_oe_n[0]}, 2'b10);
		@(posedge ref_clk);
		special_en <= 16'h0;
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		settle();
		check({pull_up_en, pull_dn_en, pin_oe_n}, 48'h7000_0800_9fff);
		rd(gpaf_a_mode, gpaf_rst_mode_a);
		rd(gpaf_a_bias, gpaf_rst_bias_a);
		rd(gpaf_a_fsel_hi, 32'h0);
		bus(1'b0, gpaf_a_freeze, 32'h0, 4'hf);
		check(q[16], 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
